// ### rorp_remote_output.sv
// Remote output port: data words, retention, terminal mapping, Wishbone slave
`timescale 1ns/1ns
`default_nettype none
`include "rorp_consts.svh"

module rorp_remote_output #(
  parameter int WORD_W = 12,
  parameter int N_TERM = 3
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_comm_wr,
  input wire logic i_comm_word_sel,
  input wire logic [WORD_W-1:0] i_comm_data,
  input wire logic i_comm_link_up,
  input wire logic i_power_off,
  input wire logic i_power_on,
  input wire logic i_inv_reset,
  input wire logic [N_TERM-1:0] i_func_out,
  input wire logic i_ext_fitted,
  input wire logic i_relay_fitted,
  output logic [N_TERM-1:0] o_term_out,
  output logic [`RORP_EXT_N-1:0] o_ext_out,
  output logic [`RORP_RELAY_N-1:0] o_relay_out
);

  localparam int SYNC_W = N_TERM + 5;
  localparam logic [3:0] TERM_BIT [3] = '{`RORP_BIT_RUN, `RORP_BIT_FDET,
                                          `RORP_BIT_FAULT};
  // Refuse widths the bit map cannot serve
  if (WORD_W < 10 || WORD_W > 16 || N_TERM < 1 || N_TERM > 3) begin : g_chk
    $error("rorp_remote_output: unsupported WORD_W or N_TERM");
  end
  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge
  // Only the four documented selection codes are accepted
  function automatic logic ret_legal(input logic [3:0] v);
    return v == `RORP_RET_CLR_CLR || v == `RORP_RET_KEEP_CLR ||
           v == `RORP_RET_CLR_KEEP || v == `RORP_RET_KEEP_KEEP;
  endfunction : ret_legal
  // Pin synchronisers; first stage is read only by the second
  logic [SYNC_W-1:0] sync1_q, sync2_q, sync_d;
  logic [1:0] edge_q;
  assign sync_d = {i_relay_fitted, i_ext_fitted, i_func_out, i_inv_reset,
                   i_power_on, i_power_off};
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      edge_q <= 2'b00;
    end else begin
      sync1_q <= sync_d;
      sync2_q <= sync1_q;
      edge_q <= sync2_q[1:0];
    end
  end
  // Synchronised pin levels and power edges
  logic off_s, on_s, inv_s, ext_fit_s, rly_fit_s, off_evt, on_evt;
  logic [N_TERM-1:0] func_s;
  assign off_s = sync2_q[0];
  assign on_s = sync2_q[1];
  assign inv_s = sync2_q[2];
  assign func_s = sync2_q[N_TERM+2:3];
  assign ext_fit_s = sync2_q[N_TERM+3];
  assign rly_fit_s = sync2_q[N_TERM+4];
  assign off_evt = off_s && !edge_q[0];
  assign on_evt = on_s && !edge_q[1];
  // Wishbone classic slave: ack one cycle after the strobe, write at ack
  logic ack_q, ack_d, bus_wr;
  logic [31:0] rd_q, rd_d;
  assign bus_wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_q;
  // Register state
  logic [3:0] ret_q, ret_d;
  logic [WORD_W-1:0] lo_q, lo_d, hi_q, hi_d;
  logic [WORD_W-1:0] nv_lo_q, nv_lo_d, nv_hi_q, nv_hi_d;
  rorp_pkg::rorp_fsel_t fsel_q [N_TERM], fsel_d [N_TERM];
  rorp_pkg::rorp_phase_t phase_q, phase_d;
  logic [31:0] fsel_word, stat_word, wtmp;
  logic comm_lo_wr, comm_hi_wr;
  // Packed views for read-back
  always_comb begin
    fsel_word = '0;
    for (int t = 0; t < N_TERM; t++) begin
      fsel_word[8*t +: 8] = fsel_q[t];
    end
  end
  assign stat_word = 32'({rly_fit_s, ext_fit_s,
                          phase_q == rorp_pkg::PH_OFF,
                          phase_q == rorp_pkg::PH_INVRST, 3'(o_term_out)});
  // Bus wins a same-cycle clash on the same word; comm write is dropped
  assign comm_lo_wr = i_comm_wr && !i_comm_word_sel &&
                      !(bus_wr && i_wb_adr == `RORP_ADR_LO);
  assign comm_hi_wr = i_comm_wr && i_comm_word_sel &&
                      !(bus_wr && i_wb_adr == `RORP_ADR_HI);
  // Bus answer: registered read data, unmapped reads return zero
  always_comb begin
    ack_d = i_wb_cyc && i_wb_stb && !ack_q;
    rd_d = rd_q;
    if (ack_d) begin
      case (i_wb_adr)
        `RORP_ADR_RET: rd_d = 32'(ret_q);
        `RORP_ADR_LO: rd_d = 32'(lo_q);
        `RORP_ADR_HI: rd_d = 32'(hi_q);
        `RORP_ADR_FSEL: rd_d = fsel_word;
        `RORP_ADR_STAT: rd_d = stat_word;
        default: rd_d = `RORP_RST_RDATA;
      endcase
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
      rd_q <= `RORP_RST_RDATA;
    end else begin
      ack_q <= ack_d;
      rd_q <= rd_d;
    end
  end
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rd_q;
  // Next register values: writes first, power and reset events override
  always_comb begin
    ret_d = ret_q;
    lo_d = lo_q;
    hi_d = hi_q;
    nv_lo_d = nv_lo_q;
    nv_hi_d = nv_hi_q;
    fsel_d = fsel_q;
    phase_d = phase_q;
    wtmp = '0;
    if (bus_wr) begin
      case (i_wb_adr)
        `RORP_ADR_RET: begin
          wtmp = lane_merge(32'(ret_q), i_wb_dat, i_wb_sel);
          if (ret_legal(wtmp[3:0])) begin
            ret_d = wtmp[3:0];
          end
        end
        `RORP_ADR_LO: begin
          wtmp = lane_merge(32'(lo_q), i_wb_dat, i_wb_sel);
          if (phase_q != rorp_pkg::PH_OFF) begin
            lo_d = wtmp[WORD_W-1:0];
          end
        end
        `RORP_ADR_HI: begin
          wtmp = lane_merge(32'(hi_q), i_wb_dat, i_wb_sel);
          if (phase_q != rorp_pkg::PH_OFF) begin
            hi_d = wtmp[WORD_W-1:0];
          end
        end
        `RORP_ADR_FSEL: begin
          wtmp = lane_merge(fsel_word, i_wb_dat, i_wb_sel);
          for (int t = 0; t < N_TERM; t++) begin
            fsel_d[t] = wtmp[8*t +: 8];
          end
        end
        default: wtmp = '0;
      endcase
    end
    if (phase_q != rorp_pkg::PH_OFF) begin
      if (comm_lo_wr) begin
        lo_d = i_comm_data;
      end
      if (comm_hi_wr) begin
        hi_d = i_comm_data;
      end
    end
    case (phase_q)
      rorp_pkg::PH_RUN: begin
        if (off_evt) begin
          phase_d = rorp_pkg::PH_OFF;
          if (ret_q[`RORP_RET_SAVE_BIT]) begin
            nv_lo_d = lo_q;
            nv_hi_d = hi_q;
          end
          lo_d = `RORP_RST_WORD;
          hi_d = `RORP_RST_WORD;
        end else if (inv_s) begin
          phase_d = rorp_pkg::PH_INVRST;
          // Only selections 10 and 11 ride through a reset
          if (ret_q == `RORP_RET_CLR_CLR || ret_q == `RORP_RET_KEEP_CLR) begin
            lo_d = `RORP_RST_WORD;
            hi_d = `RORP_RST_WORD;
          end
        end
      end
      rorp_pkg::PH_INVRST: begin
        if (off_evt) begin
          // Supply lost mid-reset: the saved image is left untouched
          phase_d = rorp_pkg::PH_OFF;
          lo_d = `RORP_RST_WORD;
          hi_d = `RORP_RST_WORD;
        end else if (!inv_s) begin
          phase_d = rorp_pkg::PH_RUN;
          if (ret_q == `RORP_RET_KEEP_CLR) begin
            lo_d = nv_lo_q;
            hi_d = nv_hi_q;
          end
        end
      end
      rorp_pkg::PH_OFF: begin
        if (on_evt) begin
          phase_d = rorp_pkg::PH_RUN;
          if (ret_q[`RORP_RET_SAVE_BIT]) begin
            lo_d = nv_lo_q;
            hi_d = nv_hi_q;
          end else begin
            lo_d = `RORP_RST_WORD;
            hi_d = `RORP_RST_WORD;
          end
        end
      end
      default: phase_d = rorp_pkg::PH_RUN;
    endcase
  end
  // Register stage; the saved image is only zeroed by the system reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ret_q <= `RORP_RST_RET;
      lo_q <= `RORP_RST_WORD;
      hi_q <= `RORP_RST_WORD;
      nv_lo_q <= `RORP_RST_WORD;
      nv_hi_q <= `RORP_RST_WORD;
      for (int t = 0; t < N_TERM; t++) begin
        fsel_q[t] <= `RORP_RST_FSEL;
      end
      phase_q <= rorp_pkg::PH_RUN;
    end else begin
      ret_q <= ret_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      nv_lo_q <= nv_lo_d;
      nv_hi_q <= nv_hi_d;
      fsel_q <= fsel_d;
      phase_q <= phase_d;
    end
  end
  // Terminal drive, one register stage after the data word
  logic [N_TERM-1:0] term_d, term_q;
  logic [`RORP_EXT_N-1:0] ext_d, ext_q;
  logic [`RORP_RELAY_N-1:0] rly_d, rly_q;
  logic powered;
  assign powered = phase_q != rorp_pkg::PH_OFF;
  for (genvar t = 0; t < N_TERM; t++) begin : g_term
    logic is_pos, is_neg;
    assign is_pos = fsel_q[t] == `RORP_FN_REM_POS;
    assign is_neg = fsel_q[t] == `RORP_FN_REM_NEG;
    // While powered, non-remote terminals pass their own function's level through
    assign term_d[t] = !powered ? 1'b0 :
                       is_pos ? lo_q[TERM_BIT[t]] :
                       is_neg ? !lo_q[TERM_BIT[t]] :
                       func_s[t];
  end

  // Option outputs exist only with the option or a live comm link
  assign ext_d = (powered && (ext_fit_s || i_comm_link_up)) ?
                 hi_q[`RORP_EXT_LSB +: `RORP_EXT_N] : '0;
  assign rly_d = (powered && (rly_fit_s || i_comm_link_up)) ?
                 hi_q[`RORP_RELAY_LSB +: `RORP_RELAY_N] : '0;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      term_q <= '0;
      ext_q <= '0;
      rly_q <= '0;
    end else begin
      term_q <= term_d;
      ext_q <= ext_d;
      rly_q <= rly_d;
    end
  end
  assign o_term_out = term_q;
  assign o_ext_out = ext_q;
  assign o_relay_out = rly_q;

  // Checks on the retention sequences, terminal mapping, communication writes and the Wishbone ack
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sequence s_save_off;
    phase_q == rorp_pkg::PH_RUN && off_evt && ret_q[`RORP_RET_SAVE_BIT];
  endsequence
  sequence s_restore_on;
    phase_q == rorp_pkg::PH_OFF && on_evt;
  endsequence

  AST_SAVE_AT_OFF: assert property (s_save_off |=>
    nv_lo_q == $past(lo_q) && nv_hi_q == $past(hi_q))
    else $error("data not saved at power-off");
  AST_RESTORE_ON: assert property (s_restore_on ##0 ret_q[0] |=>
    lo_q == $past(nv_lo_q) && hi_q == $past(nv_hi_q))
    else $error("saved data not restored at power-on");
  AST_CLEAR_ON: assert property (s_restore_on ##0 !ret_q[0] |=>
    lo_q == '0 && hi_q == '0)
    else $error("data not cleared at power-on");
  AST_INVRST_KEEP: assert property (phase_q == rorp_pkg::PH_RUN &&
    inv_s && !off_evt && ret_q[3] && !bus_wr && !i_comm_wr |=>
    phase_q == rorp_pkg::PH_INVRST && $stable(lo_q) && $stable(hi_q))
    else $error("data lost across inverter reset");
  AST_INVRST_CLR: assert property (phase_q == rorp_pkg::PH_RUN &&
    inv_s && !off_evt && !ret_q[3] |=> lo_q == '0 && hi_q == '0)
    else $error("data not cleared on inverter reset");
  AST_RELOAD: assert property (phase_q == rorp_pkg::PH_INVRST &&
    !inv_s && !off_evt && ret_q == `RORP_RET_KEEP_CLR |=>
    lo_q == $past(nv_lo_q) && hi_q == $past(nv_hi_q))
    else $error("saved state not reapplied after reset");
  AST_NO_SAVE_MIDRST: assert property (phase_q == rorp_pkg::PH_INVRST &&
    off_evt |=> $stable(nv_lo_q) && $stable(nv_hi_q))
    else $error("data saved during inverter reset");
  AST_TERM_POS: assert property (powered &&
    fsel_q[0] == `RORP_FN_REM_POS && $stable(fsel_q[0]) |=>
    o_term_out[0] == $past(lo_q[`RORP_BIT_RUN]))
    else $error("positive remote terminal mismatch");
  AST_TERM_NEG: assert property (powered &&
    fsel_q[0] == `RORP_FN_REM_NEG |=>
    o_term_out[0] == !$past(lo_q[`RORP_BIT_RUN]))
    else $error("negative remote terminal mismatch");
  AST_NON_REM: assert property (powered &&
    fsel_q[0] != `RORP_FN_REM_POS && fsel_q[0] != `RORP_FN_REM_NEG |=>
    o_term_out[0] == $past(func_s[0]))
    else $error("non-remote terminal not following its function");
  AST_COMM_WR: assert property (phase_q == rorp_pkg::PH_RUN &&
    comm_lo_wr && !bus_wr && !off_evt && !inv_s |=>
    lo_q == $past(i_comm_data) ##1 ($past(fsel_q[0]) != `RORP_FN_REM_POS ||
    o_term_out[0] == $past(lo_q[`RORP_BIT_RUN])))
    else $error("communication write not applied");
  AST_WB_ACK: assert property (i_wb_cyc && i_wb_stb && !ack_q |=>
    o_wb_ack ##1 !o_wb_ack)
    else $error("wishbone ack not a one-cycle pulse after request");

endmodule : rorp_remote_output
`default_nettype wire

// ### rorp_consts.svh
// Offsets, codes, bit positions and reset values of the remote output port
`ifndef RORP_CONSTS_SVH
`define RORP_CONSTS_SVH
// Register byte offsets
`define RORP_ADR_RET 8'h00
`define RORP_ADR_LO 8'h04
`define RORP_ADR_HI 8'h08
`define RORP_ADR_FSEL 8'h0C
`define RORP_ADR_STAT 8'h10
// Retention selection codes (decimal 0, 1, 10, 11)
`define RORP_RET_CLR_CLR 4'h0
`define RORP_RET_KEEP_CLR 4'h1
`define RORP_RET_CLR_KEEP 4'hA
`define RORP_RET_KEEP_KEEP 4'hB
// Retention bit that asks for a save at power-off
`define RORP_RET_SAVE_BIT 0
// Terminal function codes for the remote output function (96, 196)
`define RORP_FN_REM_POS 8'h60
`define RORP_FN_REM_NEG 8'hC4
// Low word terminal bit positions
`define RORP_BIT_RUN 4'h0
`define RORP_BIT_FDET 4'h4
`define RORP_BIT_FAULT 4'h5
// High word fields
`define RORP_EXT_LSB 0
`define RORP_EXT_N 7
`define RORP_RELAY_LSB 7
`define RORP_RELAY_N 3
// Status bit positions
`define RORP_ST_INVRST 3
`define RORP_ST_OFF 4
`define RORP_ST_EXTFIT 5
`define RORP_ST_RLYFIT 6
// Reset values
`define RORP_RST_RET 4'h0
`define RORP_RST_WORD 12'h000
`define RORP_RST_FSEL 8'h00
`define RORP_RST_RDATA 32'h0000_0000
`endif

// ### rorp_pkg.sv
// Types shared by the remote output port
`default_nettype none
package rorp_pkg;
  // Power and reset phase of the port
  typedef enum logic [1:0] {
    PH_RUN,
    PH_INVRST,
    PH_OFF
  } rorp_phase_t;
  typedef logic [7:0] rorp_fsel_t;
endpackage : rorp_pkg
`default_nettype wire

// ### rorp_load_model.sv
// Model of the equipment wired to the remote output terminals
`timescale 1ns/1ns
`default_nettype none
module rorp_load_model (
  input wire logic i_clock,
  input wire logic [2:0] i_func_cmd,
  input wire logic [1:0] i_fit_cmd,
  output logic [2:0] o_func_out,
  output logic o_ext_fitted,
  output logic o_relay_fitted
);
  logic [4:0] pins_d;
  logic [4:0] pins_q;
  // Own-function levels and option presence, one edge late like real wiring
  always_comb begin
    pins_d = {i_fit_cmd, i_func_cmd};
  end
  always_ff @(posedge i_clock) begin
    pins_q <= pins_d;
  end
  assign o_func_out = pins_q[2:0];
  assign o_ext_fitted = pins_q[3];
  assign o_relay_fitted = pins_q[4];
endmodule : rorp_load_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the remote output port
`timescale 1ns/1ns
`default_nettype none
`include "rorp_consts.svh"
module testbench;
  logic i_clock, i_rst_b, cyc, stb, we, ack, comm_wr, comm_sel, link_up;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, d, f;
  logic [3:0] sel, r;
  logic [2:0] pins, func_cmd, func_out, term, t;
  logic [1:0] fit_cmd;
  logic ext_fit, rly_fit, b;
  logic [6:0] ext_out;
  logic [2:0] rly_out;
  logic [11:0] comm_data, v, img, cur;
  logic [7:0] c;
  logic [31:0] exp_q[$];
  int error_cnt, n_tests, seed;

  rorp_remote_output DUT (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_comm_wr(comm_wr), .i_comm_word_sel(comm_sel),
    .i_comm_data(comm_data), .i_comm_link_up(link_up),
    .i_power_off(pins[0]), .i_power_on(pins[1]), .i_inv_reset(pins[2]),
    .i_func_out(func_out), .i_ext_fitted(ext_fit),
    .i_relay_fitted(rly_fit), .o_term_out(term), .o_ext_out(ext_out),
    .o_relay_out(rly_out));
  rorp_load_model u_load (.i_clock(i_clock), .i_func_cmd(func_cmd),
    .i_fit_cmd(fit_cmd), .o_func_out(func_out), .o_ext_fitted(ext_fit),
    .o_relay_fitted(rly_fit));

  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, expv);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= x;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge i_clock);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'h0, a, 32'h0000_0000);
  endtask : rd

  // Async pins get time for synchronisers and the output stage
  task automatic pin(input int k, input logic lv);
    pins[k] <= lv;
    tick(6);
  endtask : pin

  // Each read answer retires the oldest noted value
  always @(posedge i_clock) begin
    if (ack === 1'h1 && we === 1'h0 && exp_q.size() > 0) begin
      chk(rdat, exp_q.pop_front());
    end
  end

  // Hang guard
  initial begin
    tick(100000);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    seed = 32'hfa50;
    {i_rst_b, cyc, stb, we, comm_wr, comm_sel, link_up} = 7'h00;
    {adr, wdat, pins, func_cmd, fit_cmd, comm_data} = 0;
    sel = 4'hf;
    img = 12'h000;
    tick(5);
    i_rst_b <= 1'h1;
    tick(1);
    // Reset values; status and unmapped places read zero
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0000_0000);
    // Twelve-bit words, random contents
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wb(1'h1, i[0] ? `RORP_ADR_HI : `RORP_ADR_LO, d);
      rd(i[0] ? `RORP_ADR_HI : `RORP_ADR_LO, {20'h0_0000, d[11:0]});
    end
    // Byte lanes: only the enabled lane of a write lands
    wb(1'h1, `RORP_ADR_LO, 32'h0000_0abc);
    sel <= 4'h2;
    wb(1'h1, `RORP_ADR_LO, 32'h0000_0512);
    sel <= 4'hf;
    rd(`RORP_ADR_LO, 32'h0000_05bc);
    // Unsupported retention code leaves the selection untouched
    wb(1'h1, `RORP_ADR_RET, 32'h0000_000b);
    wb(1'h1, `RORP_ADR_RET, 32'h0000_0005);
    rd(`RORP_ADR_RET, 32'h0000_000b);
    // Terminal mapping under both polarities and unassigned terminals
    for (int g = 0; g < 2; g++) begin
      f = g ? {8'h00, `RORP_FN_REM_POS, `RORP_FN_REM_NEG, 8'h00}
            : {8'h00, `RORP_FN_REM_NEG, 8'h00, `RORP_FN_REM_POS};
      wb(1'h1, `RORP_ADR_FSEL, f);
      for (int j = 0; j < 6; j++) begin
        d = $random(seed);
        func_cmd <= d[14:12];
        wb(1'h1, `RORP_ADR_LO, {20'h0_0000, d[11:0]});
        tick(4);
        for (int k = 0; k < 3; k++) begin
          b = d[k == 0 ? 0 : k + 3];
          c = f[8 * k +: 8];
          t[k] = (c == `RORP_FN_REM_POS) ? b :
                 (c == `RORP_FN_REM_NEG) ? !b : d[12 + k];
        end
        chk({29'h0000_0000, term}, {29'h0000_0000, t});
      end
    end
    rd(`RORP_ADR_STAT, {29'h0000_0000, t});
    // Option outputs by fitted pins or link
    for (int m = 0; m < 8; m++) begin
      fit_cmd <= m[1:0];
      link_up <= m[2];
      d = $random(seed);
      wb(1'h1, `RORP_ADR_HI, d);
      tick(4);
      chk(ext_out, (m[0] | m[2]) ? d[6:0] : 7'h00);
      chk(rly_out, (m[1] | m[2]) ? d[9:7] : 3'h0);
    end
    // Communication writes back to back, first terminal remote
    wb(1'h1, `RORP_ADR_FSEL, {24'h00_0000, `RORP_FN_REM_POS});
    v = $random(seed);
    comm_wr <= 1'h1;
    comm_sel <= 1'h0;
    comm_data <= v;
    tick(1);
    comm_sel <= 1'h1;
    comm_data <= ~v;
    tick(1);
    comm_wr <= 1'h0;
    tick(1);
    rd(`RORP_ADR_LO, {20'h0_0000, v});
    rd(`RORP_ADR_HI, {20'h0_0000, ~v});
    chk(term[0], v[0]);
    // Every retention code through inverter reset and power cycle
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : (i == 2) ? 4'ha : 4'hb;
      v = $random(seed);
      wb(1'h1, `RORP_ADR_RET, {28'h000_0000, r});
      wb(1'h1, `RORP_ADR_LO, {20'h0_0000, v});
      pin(2, 1'h1);
      rd(`RORP_ADR_LO, {20'h0_0000, r[3] ? v : 12'h000});
      wb(1'h1, `RORP_ADR_LO, {20'h0_0000, ~v});
      pin(2, 1'h0);
      cur = (r == 4'h1) ? img : ~v;
      rd(`RORP_ADR_LO, {20'h0_0000, cur});
      pin(0, 1'h1);
      wb(1'h1, `RORP_ADR_LO, 32'h0000_0fff);
      rd(`RORP_ADR_LO, 32'h0000_0000);
      if (r[0]) img = cur;
      pin(0, 1'h0);
      pin(1, 1'h1);
      pin(1, 1'h0);
      rd(`RORP_ADR_LO, {20'h0_0000, r[0] ? img : 12'h000});
    end
    // Power lost in mid reset stores nothing
    wb(1'h1, `RORP_ADR_LO, {20'h0_0000, ~img});
    pin(2, 1'h1);
    pin(0, 1'h1);
    rd(`RORP_ADR_STAT, 32'h0000_0070);
    pin(2, 1'h0);
    pin(0, 1'h0);
    pin(1, 1'h1);
    pin(1, 1'h0);
    rd(`RORP_ADR_LO, {20'h0_0000, img});
    tick(2);
    chk(32'(exp_q.size()), 32'h0000_0000);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
